/* File: common/psrw_consts.vh */
// constants for the program space read window
`ifndef PSRW_CONSTS_VH
`define PSRW_CONSTS_VH

`define PSRW_EA_W          16
`define PSRW_EA_MSB        15
`define PSRW_PAGE_W        10
`define PSRW_PAGE_EN_BIT   9
`define PSRW_PAGE_HALF_BIT 8
`define PSRW_PAGE_LO_MSB   7
`define PSRW_PM_ADDR_W     23
`define PSRW_PM_DATA_W     24
`define PSRW_BYTE_W        8
`define PSRW_LO_WORD_MSB   15
`define PSRW_UP_BYTE_LSB   16
`define PSRW_ODD_BIT       0
`define PSRW_RSP_W         16
`define PSRW_PAGE_ZERO     10'h000
`define PSRW_PAGE_FIRST    10'h200
`define PSRW_PAGE_UPPER    10'h300
`define PSRW_PAGE_LAST     10'h3FF
`define PSRW_PAGE_WORDS    15'h4000
`define PSRW_WAIT_W        3
`define PSRW_EXTRA_NONE    3'h0
`define PSRW_EXTRA_MOV     3'h1
`define PSRW_EXTRA_OTHER   3'h2
`define PSRW_EXTRA_RPT     3'h2
`define PSRW_PM_LAT        3'h2
`define PSRW_ST_IDLE       1'h0
`define PSRW_ST_BUSY       1'h1

`endif

/* File: hdl/psrw_wait_ctr.v */
// down counter that holds off the answer for the access time
`timescale 1ns/1ns
`include "psrw_consts.vh"

module psrw_wait_ctr
#(
    parameter WAIT_W = `PSRW_WAIT_W
)
(
    sys_clk,
    reset_n,
    load,
    load_val,
    count_en,
    cnt_zero
);
    input  wire              sys_clk;
    input  wire              reset_n;
    input  wire              load;
    input  wire [WAIT_W-1:0] load_val;
    input  wire              count_en;
    output wire              cnt_zero;

    reg [WAIT_W-1:0] cnt_q;
    reg [WAIT_W-1:0] cnt_d;

    // load wins over counting
    always @*
    begin
        cnt_d = cnt_q;
        if (load)
            cnt_d = load_val;
        else if (count_en && (cnt_q != {WAIT_W{1'b0}}))
            cnt_d = cnt_q - {{(WAIT_W-1){1'b0}}, 1'b1};
    end

    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            cnt_q <= {WAIT_W{1'b0}};
        else
            cnt_q <= cnt_d;
    end

    assign cnt_zero = (cnt_q == {WAIT_W{1'b0}});

endmodule

/* File: hdl/psrw_bridge.v */
// program space read window between core data reads and program memory
`timescale 1ns/1ns
`include "psrw_consts.vh"

// How it works
// - The upper half of data space can be pointed at any page of program memory, each page holding a fixed count of program words.
// - A read goes to program memory only when the address top bit and the read page top bit are both one.
// - The program address is the low eight read page bits above the fifteen low pointer bits, 23 bits in all.
// - Read page bit 8 picks the lower program word when zero and the upper word when one.
// - There are 512 window pages, 200h to 3FFh, the lower half mapping lower words and the upper half upper words.
// - Lower word pages map to even program addresses 000000h to 7FFFFEh and only reads pass, never writes.
// - Upper word pages map to odd program addresses 000001h to 7FFFFFh for reads only, half of those bytes being phantom.
// - An indirect access at or above 8000h with the read or write page equal to zero raises an address error trap.
// - Outside a repeat loop a window access takes one extra cycle for word and double moves and two for all else.
// - Inside a repeat loop the first, last, interrupt exit and re-entry iterations take two extra cycles.
// - Every other repeat loop iteration completes its window access with no extra cycle.

module psrw_bridge
#(
    parameter WAIT_W = `PSRW_WAIT_W
)
(
    sys_clk,
    reset_n,
    req_valid,
    req_ready,
    req_write,
    req_indirect,
    req_byte,
    req_word_op,
    effective_addr,
    read_page_register,
    write_page_register,
    rpt_active,
    rpt_first,
    rpt_last,
    rpt_irq_exit,
    rpt_irq_reentry,
    window_hit,
    write_refused,
    addr_err_trap,
    rsp_valid,
    rsp_data,
    pm_rd_en,
    pm_addr,
    pm_upper,
    pm_rd_data
);
    input  wire                         sys_clk;
    input  wire                         reset_n;
    input  wire                         req_valid;
    output wire                         req_ready;
    input  wire                         req_write;
    input  wire                         req_indirect;
    input  wire                         req_byte;
    input  wire                         req_word_op;
    input  wire [`PSRW_EA_W-1:0]        effective_addr;
    input  wire [`PSRW_PAGE_W-1:0]      read_page_register;
    input  wire [`PSRW_PAGE_W-1:0]      write_page_register;
    input  wire                         rpt_active;
    input  wire                         rpt_first;
    input  wire                         rpt_last;
    input  wire                         rpt_irq_exit;
    input  wire                         rpt_irq_reentry;
    output wire                         window_hit;
    output wire                         write_refused;
    output wire                         addr_err_trap;
    output wire                         rsp_valid;
    output wire [`PSRW_RSP_W-1:0]       rsp_data;
    output wire                         pm_rd_en;
    output wire [`PSRW_PM_ADDR_W-1:0]   pm_addr;
    output wire                         pm_upper;
    input  wire [`PSRW_PM_DATA_W-1:0]   pm_rd_data;

    // page equals zero, used for both page registers
    function page_is_zero;
        input [`PSRW_PAGE_W-1:0] page;
        begin
            page_is_zero = (page == `PSRW_PAGE_ZERO);
        end
    endfunction

    // window page: 200h..3FFh, all with the top bit set
    function page_in_window;
        input [`PSRW_PAGE_W-1:0] page;
        begin
            page_in_window = (page >= `PSRW_PAGE_FIRST)
                             && (page <= `PSRW_PAGE_LAST);
        end
    endfunction

    // one byte of the captured word, zero extended
    function [`PSRW_RSP_W-1:0] byte_ext;
        input [`PSRW_BYTE_W-1:0] b;
        begin
            byte_ext = {{(`PSRW_RSP_W-`PSRW_BYTE_W){1'b0}}, b};
        end
    endfunction

    reg                          state_q;
    reg                          state_d;
    reg                          upper_q;
    reg                          byte_q;
    reg                          odd_q;
    reg                          cap_pend_q;
    reg [`PSRW_PM_DATA_W-1:0]    cap_data_q;
    reg [`PSRW_RSP_W-1:0]        sel_data;
    reg [WAIT_W-1:0]             extra;
    reg                          window_hit_q;
    reg                          write_refused_q;
    reg                          addr_err_trap_q;
    reg                          rsp_valid_q;
    reg [`PSRW_RSP_W-1:0]        rsp_data_q;
    reg                          pm_rd_en_q;
    reg [`PSRW_PM_ADDR_W-1:0]    pm_addr_q;
    reg                          pm_upper_q;
    wire                         take;
    wire                         ea_high;
    wire                         pg_zero;
    wire                         rd_hit;
    wire                         wr_hit;
    wire                         trap;
    wire                         cnt_zero;
    wire [WAIT_W-1:0]            wait_load;
    wire                         busy;
    wire                         rsp_fire;
    wire                         rpt_edge;
    wire [`PSRW_BYTE_W-1:0]      byte_lo;
    wire [`PSRW_BYTE_W-1:0]      byte_hi;
    wire [`PSRW_BYTE_W-1:0]      byte_up;

    assign busy      = (state_q == `PSRW_ST_BUSY);
    assign rsp_fire  = busy && cnt_zero;
    assign req_ready = (state_q == `PSRW_ST_IDLE);
    assign take      = req_valid && req_ready;
    assign ea_high   = effective_addr[`PSRW_EA_MSB];

    // page zero checked against the page of the access direction
    assign pg_zero = req_write ? page_is_zero(write_page_register)
                               : page_is_zero(read_page_register);
    assign trap = take && req_indirect && ea_high && pg_zero;

    // reads only, address top bit and page top bit both set
    assign rd_hit = take && !req_write && ea_high
                    && page_in_window(read_page_register);
    assign wr_hit = take && req_write && ea_high
                    && page_in_window(write_page_register);

    // iterations of a repeat loop that pay the full penalty
    assign rpt_edge = rpt_first || rpt_last
                      || rpt_irq_exit || rpt_irq_reentry;

    // extra cycles for this access
    always @*
    begin
        extra = `PSRW_EXTRA_NONE;
        if (rpt_active)
        begin
            if (rpt_edge)
                extra = `PSRW_EXTRA_RPT;
            else
                extra = `PSRW_EXTRA_NONE;
        end
        else if (req_word_op)
            extra = `PSRW_EXTRA_MOV;
        else
            extra = `PSRW_EXTRA_OTHER;
    end

    assign wait_load = `PSRW_PM_LAT + extra;

    psrw_wait_ctr
    #(
        .WAIT_W (WAIT_W)
    )
    i_psrw_wait_ctr
    (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .load     (rd_hit),
        .load_val (wait_load),
        .count_en (busy),
        .cnt_zero (cnt_zero)
    );

    always @*
    begin
        state_d = state_q;
        case (state_q)
            `PSRW_ST_IDLE:
            begin
                if (rd_hit)
                    state_d = `PSRW_ST_BUSY;
            end
            `PSRW_ST_BUSY:
            begin
                if (cnt_zero)
                    state_d = `PSRW_ST_IDLE;
            end
            default:
            begin
                state_d = `PSRW_ST_IDLE;
            end
        endcase
    end

    // the three real bytes of the captured program word
    assign byte_lo = cap_data_q[`PSRW_BYTE_W-1:0];
    assign byte_hi = cap_data_q[`PSRW_LO_WORD_MSB:`PSRW_BYTE_W];
    assign byte_up = cap_data_q[`PSRW_PM_DATA_W-1:`PSRW_UP_BYTE_LSB];

    // pick lower or upper program word, then the byte
    always @*
    begin
        sel_data = {`PSRW_RSP_W{1'b0}};
        if (!upper_q)
        begin
            sel_data = cap_data_q[`PSRW_LO_WORD_MSB:0];
            if (byte_q)
                sel_data = odd_q ? byte_ext(byte_hi)
                                 : byte_ext(byte_lo);
        end
        else
        begin
            // high byte of the upper word is phantom
            sel_data = byte_ext(byte_up);
            if (byte_q && odd_q)
                sel_data = {`PSRW_RSP_W{1'b0}};
        end
    end

    // outputs straight from their flops
    assign window_hit    = window_hit_q;
    assign write_refused = write_refused_q;
    assign addr_err_trap = addr_err_trap_q;
    assign rsp_valid     = rsp_valid_q;
    assign rsp_data      = rsp_data_q;
    assign pm_rd_en      = pm_rd_en_q;
    assign pm_addr       = pm_addr_q;
    assign pm_upper      = pm_upper_q;

    // state and one-cycle request pulses
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q         <= `PSRW_ST_IDLE;
            window_hit_q    <= 1'b0;
            write_refused_q <= 1'b0;
            addr_err_trap_q <= 1'b0;
            pm_rd_en_q      <= 1'b0;
            cap_pend_q      <= 1'b0;
        end
        else
        begin
            state_q         <= state_d;
            window_hit_q    <= rd_hit;
            write_refused_q <= wr_hit;
            addr_err_trap_q <= trap;
            pm_rd_en_q      <= rd_hit;
            cap_pend_q      <= pm_rd_en_q;
        end
    end

    // program address and the attributes of the read in flight
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pm_addr_q  <= {`PSRW_PM_ADDR_W{1'b0}};
            pm_upper_q <= 1'b0;
            upper_q    <= 1'b0;
            byte_q     <= 1'b0;
            odd_q      <= 1'b0;
        end
        else if (rd_hit)
        begin
            // low page byte over the pointer's low fifteen bits
            pm_addr_q  <= {read_page_register[`PSRW_PAGE_LO_MSB:0],
                           effective_addr[`PSRW_EA_MSB-1:0]};
            pm_upper_q <= read_page_register[`PSRW_PAGE_HALF_BIT];
            upper_q    <= read_page_register[`PSRW_PAGE_HALF_BIT];
            byte_q     <= req_byte;
            odd_q      <= effective_addr[`PSRW_ODD_BIT];
        end
    end

    // capture the memory word, then answer once the wait has run out
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cap_data_q  <= {`PSRW_PM_DATA_W{1'b0}};
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= {`PSRW_RSP_W{1'b0}};
        end
        else
        begin
            rsp_valid_q <= rsp_fire;
            if (cap_pend_q)
                cap_data_q <= pm_rd_data;
            if (rsp_fire)
                rsp_data_q <= sel_data;
        end
    end

endmodule

/* File: test/psrw_bridge_asserts.sv */
// port assertions for the program space read window
`timescale 1ns/1ns
module psrw_bridge_chk
(
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        req_write,
    input wire logic        req_indirect,
    input wire logic        req_word_op,
    input wire logic [15:0] effective_addr,
    input wire logic [9:0]  read_page_register,
    input wire logic [9:0]  write_page_register,
    input wire logic        rpt_active,
    input wire logic        rpt_first,
    input wire logic        rpt_last,
    input wire logic        rpt_irq_exit,
    input wire logic        rpt_irq_reentry,
    input wire logic        window_hit,
    input wire logic        addr_err_trap,
    input wire logic        rsp_valid,
    input wire logic        pm_rd_en,
    input wire logic [22:0] pm_addr,
    input wire logic        pm_upper
);
    wire tk = req_valid & req_ready;
    wire rd = tk & ~req_write & effective_addr[15] & read_page_register[9];
    wire rp = rpt_first | rpt_last | rpt_irq_exit | rpt_irq_reentry;
    wire [9:0] pg = req_write ? write_page_register : read_page_register;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    chk_hit_pulse:
        assert property (rd |=> window_hit && pm_rd_en)
        else $error("window read not issued");
    chk_no_read:
        assert property (tk && !rd |=> !pm_rd_en)
        else $error("program memory read without window");
    chk_addr_join:
        assert property (rd |=> pm_addr == {$past(read_page_register[7:0]),
            $past(effective_addr[14:0])})
        else $error("program address wrong");
    chk_half_sel:
        assert property (rd |=> pm_upper == $past(read_page_register[8]))
        else $error("word half select wrong");
    chk_trap_zero:
        assert property (tk && req_indirect && effective_addr[15]
            && pg == 10'h000 |=> addr_err_trap)
        else $error("address error trap missing");
    chk_mov_lat:
        assert property (rd && !rpt_active && req_word_op
            |=> !rsp_valid [*4] ##1 rsp_valid)
        else $error("move latency wrong");
    chk_other_lat:
        assert property (rd && !rpt_active && !req_word_op
            |=> !rsp_valid [*5] ##1 rsp_valid)
        else $error("other latency wrong");
    chk_rpt_slow:
        assert property (rd && rpt_active && rp
            |=> !rsp_valid [*5] ##1 rsp_valid)
        else $error("repeat edge latency wrong");
    chk_rpt_fast:
        assert property (rd && rpt_active && !rp
            |=> !rsp_valid [*3] ##1 rsp_valid)
        else $error("repeat latency wrong");
endmodule

bind psrw_bridge psrw_bridge_chk i_psrw_bridge_chk (.*);

/* File: test/psrw_pmem_model.sv */
// program memory model answering one cycle after a read strobe
`timescale 1ns/1ns
module psrw_pmem_model
(
    input  wire logic        sys_clk,
    input  wire logic        pm_rd_en,
    input  wire logic [22:0] pm_addr,
    output      logic [23:0] pm_rd_data
);
    initial pm_rd_data = 24'h000000;
    // stale word inverted when not asked
    always @(posedge sys_clk)
        pm_rd_data <= pm_rd_en ? {pm_addr[22:15], pm_addr[15:0]} ^ 24'hC35A96
                               : ~pm_rd_data;
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the program space read window
`timescale 1ns/1ns
module tb_top;
    logic        sys_clk, reset_n, req_valid, req_write, req_indirect;
    logic        req_byte, req_word_op, rpt_active, rpt_first, rpt_last;
    logic        rpt_irq_exit, rpt_irq_reentry;
    logic [15:0] effective_addr;
    logic [9:0]  read_page_register, write_page_register;
    wire         req_ready, window_hit, write_refused, addr_err_trap;
    wire         rsp_valid, pm_rd_en, pm_upper;
    wire  [15:0] rsp_data;
    wire  [22:0] pm_addr;
    wire  [23:0] pm_rd_data;
    int          n_mismatch, num_checks;

    psrw_bridge     i_psrw_bridge (.*);
    psrw_pmem_model i_psrw_pmem_model (.*);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic drive(input logic [4:0] f, input logic [15:0] ea,
        input logic [9:0] rpg, input logic [9:0] wpg, input logic [4:0] rk);
        @(posedge sys_clk);
        #1;
        {req_write, req_indirect, req_byte, req_word_op, req_valid} = f;
        effective_addr = ea;
        read_page_register = rpg;
        write_page_register = wpg;
        {rpt_active, rpt_first, rpt_last, rpt_irq_exit, rpt_irq_reentry} = rk;
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
    endtask

    task automatic rd(input logic wo, input logic by, input logic [15:0] ea,
        input logic [9:0] pg, input logic [4:0] rk, input int lat);
        logic [22:0] a;
        logic [23:0] d;
        logic [15:0] e;
        int          n;
        a = {pg[7:0], ea[14:0]};
        d = {a[22:15], a[15:0]} ^ 24'hC35A96;
        e = pg[8] ? ((by && ea[0]) ? 16'h0000 : {8'h00, d[23:16]})
            : (!by ? d[15:0] : {8'h00, ea[0] ? d[15:8] : d[7:0]});
        drive({2'b01, by, wo, 1'b1}, ea, pg, 10'h000, rk);
        check(pm_addr, a);
        check(pm_upper, pg[8]);
        check(window_hit, 1'b1);
        n = 1;
        while (rsp_valid !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(n, lat);
        check(rsp_data, e);
    endtask

    task automatic ev(input logic [4:0] f, input logic [15:0] ea,
        input logic [9:0] rpg, input logic [9:0] wpg, input logic [1:0] x);
        drive(f, ea, rpg, wpg, 5'h00);
        check({addr_err_trap, write_refused, pm_rd_en}, {x, 1'b0});
    endtask

    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial
    begin
        #20000;
        n_mismatch++;
        report_and_stop;
    end

    initial
    begin
        reset_n = 1'b0;
        {req_valid, req_write, req_indirect, req_byte, req_word_op} = 5'h00;
        {rpt_active, rpt_first, rpt_last, rpt_irq_exit, rpt_irq_reentry} = 5'h00;
        effective_addr = 16'h0000;
        read_page_register = 10'h000;
        write_page_register = 10'h000;
        repeat (2) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        check({req_ready, rsp_valid, pm_rd_en}, 3'h4);
        // lower words, word and both bytes
        rd(1'b1, 1'b0, 16'h800A, 10'h202, 5'h00, 5);
        rd(1'b1, 1'b1, 16'h800A, 10'h202, 5'h00, 5);
        rd(1'b1, 1'b1, 16'h800B, 10'h202, 5'h00, 5);
        rd(1'b1, 1'b0, 16'hFFFE, 10'h2FF, 5'h00, 5);
        // upper words and phantom byte
        rd(1'b1, 1'b0, 16'h8000, 10'h300, 5'h00, 5);
        rd(1'b1, 1'b1, 16'h8001, 10'h300, 5'h00, 5);
        rd(1'b0, 1'b1, 16'hFFFE, 10'h3FF, 5'h00, 6);
        // repeat loop iteration kinds
        for (int i = 0; i < 4; i++)
            rd(1'b1, 1'b0, 16'h9000, 10'h2A5, 5'h10 | (5'h08 >> i), 6);
        rd(1'b1, 1'b0, 16'h9002, 10'h2A5, 5'h10, 4);
        // refused write, traps, non-window read
        ev(5'h1B, 16'h9000, 10'h202, 10'h202, 2'b01);
        ev(5'h0B, 16'h9000, 10'h000, 10'h202, 2'b10);
        ev(5'h1B, 16'h9000, 10'h202, 10'h000, 2'b10);
        ev(5'h0B, 16'h7000, 10'h202, 10'h000, 2'b00);
        report_and_stop;
    end
endmodule
